// [logic/dcc_regs.vh]
/*
 * Register addresses, field positions, reset values and timing counts of
 * the converter control block.
 * Assumes a 200 MHz system clock; included by its bare name.
 */
`ifndef DCC_REGS_VH
`define DCC_REGS_VH

// ------------------------------------------------------------
// byte addresses of the instruction (4 bits)
// ------------------------------------------------------------
`define DCC_ADDR_DATA_HI    4'h0
`define DCC_ADDR_DATA_LO    4'h1
`define DCC_ADDR_CTRL_HI    4'h4
`define DCC_ADDR_CTRL_LO    4'h5
`define DCC_ADDR_OFS_B2     4'h8
`define DCC_ADDR_OFS_B1     4'h9
`define DCC_ADDR_OFS_B0     4'hA
`define DCC_ADDR_FS_B2      4'hC
`define DCC_ADDR_FS_B1      4'hD
`define DCC_ADDR_FS_B0      4'hE

// ------------------------------------------------------------
// instruction byte fields
// ------------------------------------------------------------
`define DCC_INS_RW_BIT      7
`define DCC_INS_CNT_HI      6
`define DCC_INS_CNT_LO      5

// ------------------------------------------------------------
// control word fields (16 bits)
// ------------------------------------------------------------
`define DCC_CW_CRST_BIT     9
`define DCC_CW_CLR_BIT      7
`define DCC_CW_FMT_BIT      6
`define DCC_CW_BD_BIT       4
`define DCC_CW_MSB_BIT      3
`define DCC_CW_MODE_HI      1
`define DCC_CW_MODE_LO      0
`define DCC_CW_RESET        16'h2802
`define DCC_MODE_NORMAL     2'h0
`define DCC_MODE_SELFCAL    2'h1
`define DCC_MODE_SLEEP      2'h2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DCC_OFS_RESET       24'h000000
`define DCC_FS_RESET        24'h800000
`define DCC_DATA_RESET      16'h0000

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define DCC_CLK_MHZ         200
`define DCC_TIMEOUT_MS      100
`define DCC_TIMEOUT_CYC     (`DCC_TIMEOUT_MS * 1000 * `DCC_CLK_MHZ)
`define DCC_WAKE_CYC        16'h0400
`define DCC_RSTPAT_CYC      32'h00000100

`endif

// [logic/dcc_converter_ctrl.v]
/*
 * Digital control of a serial-programmed voltage-output converter:
 * serial link slave, calibration registers, input data register,
 * sleep entry and exit, serial time-out recovery.
 * Assumes serial clock, data and select come from a host outside the
 * clock domain; the analogue self-calibration engine reports its result.
 */
`timescale 1ns/10ps
`default_nettype none
`include "dcc_regs.vh"

module dcc_converter_ctrl #(
	parameter [31:0] TIMEOUT_CYC = `DCC_TIMEOUT_CYC
) (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        sclkPin,
	input  wire        csPin_n,
	input  wire        sdioIn,
	output reg         sdioOut,
	output reg         sdioOe,
	input  wire        calDone,
	input  wire [23:0] calOffset,
	input  wire [23:0] calFullScale,
	output reg  [15:0] modCode,
	output reg  [23:0] modOffset,
	output reg  [23:0] modFullScale,
	output reg         modLoad,
	output wire        analogSleep,
	output wire        analogReady,
	output wire        outHighZ,
	output wire [15:0] controlWord
);

// ------------------------------------------------------------
// pin synchronisers
// ------------------------------------------------------------
reg [1:0] sclkSync_reg;
reg [1:0] csSync_reg;
reg [1:0] sdiSync_reg;
reg       sclkDly_reg;
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		sclkSync_reg <= 2'h0;
		csSync_reg   <= 2'h3;
		sdiSync_reg  <= 2'h0;
		sclkDly_reg  <= 1'b0;
	end else begin
		sclkSync_reg <= {sclkSync_reg[0], sclkPin};
		csSync_reg   <= {csSync_reg[0], csPin_n};
		sdiSync_reg  <= {sdiSync_reg[0], sdioIn};
		sclkDly_reg  <= sclkSync_reg[1];
	end
end
wire sclk     = sclkSync_reg[1];
wire csActive = ~csSync_reg[1];
wire sclkRise = sclk & ~sclkDly_reg;
wire sclkFall = ~sclk & sclkDly_reg;

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg  [23:0] offsetCorr_reg;
reg  [23:0] fullScaleCorr_reg;
reg  [15:0] inputData_reg;
reg  [15:0] controlWord_reg;
reg  [15:0] ctrlShadow_reg;
reg  [15:0] dataShadow_reg;
assign controlWord = controlWord_reg;
wire [1:0] opMode         = controlWord_reg[`DCC_CW_MODE_HI:`DCC_CW_MODE_LO];
wire       inputFormatSel = controlWord_reg[`DCC_CW_FMT_BIT];
wire       byteDown       = controlWord_reg[`DCC_CW_BD_BIT];
wire       lsbFirst       = controlWord_reg[`DCC_CW_MSB_BIT];

// read one register byte by address
function [7:0] readByte;
	input [3:0] a;
	begin
		case (a)
			`DCC_ADDR_DATA_HI: readByte = inputData_reg[15:8];
			`DCC_ADDR_DATA_LO: readByte = inputData_reg[7:0];
			`DCC_ADDR_CTRL_HI: readByte = controlWord_reg[15:8];
			`DCC_ADDR_CTRL_LO: readByte = controlWord_reg[7:0];
			`DCC_ADDR_OFS_B2:  readByte = offsetCorr_reg[23:16];
			`DCC_ADDR_OFS_B1:  readByte = offsetCorr_reg[15:8];
			`DCC_ADDR_OFS_B0:  readByte = offsetCorr_reg[7:0];
			`DCC_ADDR_FS_B2:   readByte = fullScaleCorr_reg[23:16];
			`DCC_ADDR_FS_B1:   readByte = fullScaleCorr_reg[15:8];
			`DCC_ADDR_FS_B0:   readByte = fullScaleCorr_reg[7:0];
			default:           readByte = 8'h00;
		endcase
	end
endfunction

// bit reversal for least significant bit first transfers
function [7:0] bitOrder;
	input [7:0] b;
	input       rev;
	begin
		bitOrder = rev ? {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]} : b;
	end
endfunction

// ------------------------------------------------------------
// serial link state machine
// ------------------------------------------------------------
localparam [1:0] ST_INSTR = 2'h0;
localparam [1:0] ST_WRITE = 2'h1;
localparam [1:0] ST_READ  = 2'h2;

reg  [1:0]  state_reg;
reg  [2:0]  bitCnt_reg;
reg  [7:0]  shift_reg;
reg  [3:0]  addr_reg;
reg  [1:0]  bytesLeft_reg;
reg         touchData_reg;
reg         touchCtrl_reg;
reg  [31:0] idleCnt_reg;
wire [7:0]  shiftNext = {shift_reg[6:0], sdiSync_reg[1]};
wire        byteDone  = sclkFall & (bitCnt_reg == 3'h7);
wire        lastByte  = (bytesLeft_reg == 2'h0);
wire [3:0]  addrNext  = byteDown ? addr_reg - 4'h1 : addr_reg + 4'h1;
wire [7:0]  wrByte    = bitOrder(shiftNext, lsbFirst);
wire [7:0]  rdByte    = bitOrder(readByte(addr_reg), lsbFirst);
wire        midXfer   = (state_reg != ST_INSTR) | (bitCnt_reg != 3'h0);
wire        timedOut  = midXfer & (idleCnt_reg >= TIMEOUT_CYC - 32'h1);

// duty pattern reset: serial clock held high long enough, even mid-transfer
reg  [31:0] highCnt_reg;
wire        patReset = (highCnt_reg == `DCC_RSTPAT_CYC);
always @(posedge clk_sys or posedge rst) begin
	if (rst)
		highCnt_reg <= 32'h0;
	else if (!sclk)
		highCnt_reg <= 32'h0;
	else if (!patReset)
		highCnt_reg <= highCnt_reg + 32'h1;
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		state_reg     <= ST_INSTR;
		bitCnt_reg    <= 3'h0;
		shift_reg     <= 8'h00;
		addr_reg      <= 4'h0;
		bytesLeft_reg <= 2'h0;
		touchData_reg <= 1'b0;
		touchCtrl_reg <= 1'b0;
		idleCnt_reg   <= 32'h0;
		sdioOut       <= 1'b0;
		sdioOe        <= 1'b0;
	end else if (timedOut || patReset || !csActive) begin
		state_reg     <= ST_INSTR;
		bitCnt_reg    <= 3'h0;
		touchData_reg <= 1'b0;
		touchCtrl_reg <= 1'b0;
		idleCnt_reg   <= 32'h0;
		sdioOe        <= csActive ? 1'b0 : sdioOe & (state_reg == ST_READ);
	end else begin
		idleCnt_reg <= (sclkRise || sclkFall) ? 32'h0 : idleCnt_reg + 32'h1;
		if (sclkRise && state_reg == ST_READ)
			sdioOut <= rdByte[3'h7 - bitCnt_reg];
		if (sclkFall) begin
			shift_reg  <= shiftNext;
			bitCnt_reg <= bitCnt_reg + 3'h1;
		end
		if (byteDone) begin
			case (state_reg)
				ST_INSTR: begin
					addr_reg      <= shiftNext[3:0];
					bytesLeft_reg <= shiftNext[`DCC_INS_CNT_HI:`DCC_INS_CNT_LO];
					state_reg     <= shiftNext[`DCC_INS_RW_BIT] ? ST_READ : ST_WRITE;
					sdioOe        <= shiftNext[`DCC_INS_RW_BIT];
				end
				ST_WRITE, ST_READ: begin
					addr_reg      <= addrNext;
					bytesLeft_reg <= bytesLeft_reg - 2'h1;
					if (state_reg == ST_WRITE) begin
						touchData_reg <= touchData_reg | (addr_reg[3:1] == 3'h0);
						touchCtrl_reg <= touchCtrl_reg | (addr_reg[3:1] == 3'h2);
					end
					if (lastByte) begin
						state_reg     <= ST_INSTR;
						sdioOe        <= 1'b0;
						touchData_reg <= 1'b0;
						touchCtrl_reg <= 1'b0;
					end
				end
				default: state_reg <= ST_INSTR;
			endcase
		end
	end
end

// ------------------------------------------------------------
// register writes
// ------------------------------------------------------------
wire wrStrobe  = byteDone & (state_reg == ST_WRITE) & csActive & ~timedOut & ~patReset;
wire endWrite  = wrStrobe & lastByte;
wire dataDone  = endWrite & (touchData_reg | (addr_reg[3:1] == 3'h0));
wire ctrlDone  = endWrite & (touchCtrl_reg | (addr_reg[3:1] == 3'h2));
reg  [15:0] dataNext;
reg  [15:0] ctrlNext;
always @* begin
	dataNext = dataShadow_reg;
	ctrlNext = ctrlShadow_reg;
	if (wrStrobe) begin
		if (addr_reg == `DCC_ADDR_DATA_HI) dataNext[15:8] = wrByte;
		if (addr_reg == `DCC_ADDR_DATA_LO) dataNext[7:0]  = wrByte;
		if (addr_reg == `DCC_ADDR_CTRL_HI) ctrlNext[15:8] = wrByte;
		if (addr_reg == `DCC_ADDR_CTRL_LO) ctrlNext[7:0]  = wrByte;
	end
end

always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		controlWord_reg   <= `DCC_CW_RESET;
		ctrlShadow_reg    <= `DCC_CW_RESET;
		dataShadow_reg    <= `DCC_DATA_RESET;
		inputData_reg     <= `DCC_DATA_RESET;
		offsetCorr_reg    <= `DCC_OFS_RESET;
		fullScaleCorr_reg <= `DCC_FS_RESET;
	end else begin
		dataShadow_reg <= dataNext;
		ctrlShadow_reg <= ctrlNext;
		if (dataDone)
			inputData_reg <= dataNext;
		else if (controlWord_reg[`DCC_CW_CLR_BIT])
			inputData_reg <= `DCC_DATA_RESET;
		if (ctrlDone)
			controlWord_reg <= ctrlNext;
		if (wrStrobe && addr_reg == `DCC_ADDR_OFS_B2) offsetCorr_reg[23:16] <= wrByte;
		if (wrStrobe && addr_reg == `DCC_ADDR_OFS_B1) offsetCorr_reg[15:8]  <= wrByte;
		if (wrStrobe && addr_reg == `DCC_ADDR_OFS_B0) offsetCorr_reg[7:0]   <= wrByte;
		if (wrStrobe && addr_reg == `DCC_ADDR_FS_B2) fullScaleCorr_reg[23:16] <= wrByte;
		if (wrStrobe && addr_reg == `DCC_ADDR_FS_B1) fullScaleCorr_reg[15:8]  <= wrByte;
		if (wrStrobe && addr_reg == `DCC_ADDR_FS_B0) fullScaleCorr_reg[7:0]   <= wrByte;
		if (calDone && opMode == `DCC_MODE_SELFCAL) begin
			offsetCorr_reg    <= calOffset ^ 24'h800000;
			fullScaleCorr_reg <= calFullScale;
			controlWord_reg[`DCC_CW_MODE_HI:`DCC_CW_MODE_LO] <= `DCC_MODE_NORMAL;
		end
		if (controlWord_reg[`DCC_CW_CRST_BIT]) begin
			offsetCorr_reg    <= `DCC_OFS_RESET;
			fullScaleCorr_reg <= `DCC_FS_RESET;
		end
	end
end

// ------------------------------------------------------------
// sleep and power-up sequence
// ------------------------------------------------------------
reg  [15:0] wakeCnt_reg;
wire asleep = (opMode == `DCC_MODE_SLEEP);
always @(posedge clk_sys or posedge rst) begin
	if (rst)
		wakeCnt_reg <= `DCC_WAKE_CYC;
	else if (asleep)
		wakeCnt_reg <= `DCC_WAKE_CYC;
	else if (wakeCnt_reg != 16'h0)
		wakeCnt_reg <= wakeCnt_reg - 16'h1;
end
assign analogSleep = asleep;
assign analogReady = ~asleep & (wakeCnt_reg == 16'h0);
assign outHighZ    = asleep;

// ------------------------------------------------------------
// modulator hand-off
// ------------------------------------------------------------
always @(posedge clk_sys or posedge rst) begin
	if (rst) begin
		modCode      <= 16'h0000;
		modOffset    <= `DCC_OFS_RESET;
		modFullScale <= `DCC_FS_RESET;
		modLoad      <= 1'b0;
	end else begin
		// code 8000 or 0000 is zero
		modCode      <= inputFormatSel ? inputData_reg : inputData_reg ^ 16'h8000;
		modOffset    <= offsetCorr_reg;
		modFullScale <= fullScaleCorr_reg;
		modLoad      <= dataDone & analogReady;
	end
end

endmodule
`default_nettype wire

// [sim/dcc_host_model.sv]
/* serial host model: drives clock, select and data of the converter link.
   assumes the bench calls its tasks and wires sdioWire to the data input. */
`timescale 1ns/10ps
`default_nettype none
module dcc_host_model (
	input  wire logic clk_sys,
	input  wire logic sdioOut,
	input  wire logic sdioOe,
	output var  logic sclkPin,
	output var  logic csPin_n,
	output wire logic sdioWire
);
	logic hostBit;
	// released line shows the inverse of its last value
	assign sdioWire = sdioOe ? sdioOut : hostBit;
	initial begin
		sclkPin = 1'b0;
		csPin_n = 1'b0;
		hostBit = 1'b0;
	end
	task automatic bitx(input logic drv, input logic b, output logic r);
		#24 hostBit = drv ? b : ~hostBit;
		#16 sclkPin = 1'b1;
		#24 r = sdioWire;
		sclkPin = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] ins, input int nSend, input logic [23:0] wd, output logic [23:0] rd);
		logic r;
		rd = 24'h000000;
		for (int i = 7; i >= 0; i--) bitx(1'b1, ins[i], r);
		#200;
		for (int i = 8 * nSend - 1; i >= 0; i--) begin
			bitx(!ins[7], wd[i], r);
			rd = {rd[22:0], r};
		end
		#400;
	endtask
	task automatic settle(input int cyc);
		repeat (cyc) @(negedge clk_sys);
	endtask
	task automatic linkReset();
		sclkPin = 1'b1;
		repeat (300) @(negedge clk_sys);
		sclkPin = 1'b0;
		#400;
	endtask
endmodule
`default_nettype wire

// [sim/dcc_converter_ctrl_monitor.sv]
/* checker of the converter control block, bound to its ports.
   assumes one system clock and an active-high asynchronous reset. */
`timescale 1ns/10ps
`default_nettype none
module dcc_converter_ctrl_monitor (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        sclkPin,
	input wire logic        csPin_n,
	input wire logic        sdioIn,
	input wire logic        sdioOut,
	input wire logic        sdioOe,
	input wire logic        calDone,
	input wire logic [23:0] calOffset,
	input wire logic [23:0] calFullScale,
	input wire logic [15:0] modCode,
	input wire logic [23:0] modOffset,
	input wire logic [23:0] modFullScale,
	input wire logic        modLoad,
	input wire logic        analogSleep,
	input wire logic        analogReady,
	input wire logic        outHighZ,
	input wire logic [15:0] controlWord
);
	logic [7:0]  quiet_reg;
	logic        sclkLast_reg;
	logic [10:0] awake_reg;
	// cycles since the last serial clock edge or calibration result
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			quiet_reg <= 8'h00;
			sclkLast_reg <= 1'b0;
			awake_reg <= 11'h000;
		end else begin
			sclkLast_reg <= sclkPin;
			// cycles spent awake, saturating
			if (analogSleep)
				awake_reg <= 11'h000;
			else if (awake_reg != 11'h7FF)
				awake_reg <= awake_reg + 11'h001;
			if (sclkPin != sclkLast_reg || calDone)
				quiet_reg <= 8'h00;
			else if (quiet_reg != 8'hFF)
				quiet_reg <= quiet_reg + 8'h01;
		end
	end
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_calTaken;
		calDone && controlWord[1:0] == 2'h1;
	endsequence
	sequence s_wakeHold;
		!analogReady [*8];
	endsequence
	property p_sleepFlag; $stable(controlWord) |-> analogSleep == (controlWord[1:0] == 2'h2); endproperty
	a_sleepFlag: assert property (p_sleepFlag) else $error("sleep flag wrong");
	property p_sleepZ; analogSleep |-> outHighZ; endproperty
	a_sleepZ: assert property (p_sleepZ) else $error("output driven in sleep");
	property p_readyAwake; analogReady |-> !analogSleep && !outHighZ; endproperty
	a_readyAwake: assert property (p_readyAwake) else $error("ready while asleep");
	property p_wakeHold; $fell(analogSleep) |-> s_wakeHold; endproperty
	a_wakeHold: assert property (p_wakeHold) else $error("ready too soon after wake");
	property p_wakeDelay; !analogSleep |-> analogReady == (awake_reg >= 11'h400); endproperty
	a_wakeDelay: assert property (p_wakeDelay) else $error("power-up time wrong");
	property p_calOfs; s_calTaken |-> ##[1:3] modOffset == (calOffset ^ 24'h800000); endproperty
	a_calOfs: assert property (p_calOfs) else $error("offset result not stored");
	property p_calFs; s_calTaken |-> ##[1:3] modFullScale == calFullScale; endproperty
	a_calFs: assert property (p_calFs) else $error("full-scale result altered");
	property p_calBack; s_calTaken |-> ##[1:3] controlWord[1:0] == 2'h0; endproperty
	a_calBack: assert property (p_calBack) else $error("mode not normal after cal");
	property p_loadPulse; modLoad |-> analogReady ##1 !modLoad; endproperty
	a_loadPulse: assert property (p_loadPulse) else $error("bad load pulse");
	property p_quietHold;
		quiet_reg > 8'h14 |-> $stable(modOffset) && $stable(modFullScale) && $stable(modCode) && $stable(controlWord);
	endproperty
	a_quietHold: assert property (p_quietHold) else $error("register changed on idle link");
	property p_oeQuiet; quiet_reg > 8'h64 |-> !sdioOe; endproperty
	a_oeQuiet: assert property (p_oeQuiet) else $error("data driven on idle link");
endmodule
bind dcc_converter_ctrl dcc_converter_ctrl_monitor u_mon (
	.clk_sys(clk_sys), .rst(rst), .sclkPin(sclkPin), .csPin_n(csPin_n), .sdioIn(sdioIn),
	.sdioOut(sdioOut), .sdioOe(sdioOe), .calDone(calDone), .calOffset(calOffset),
	.calFullScale(calFullScale), .modCode(modCode), .modOffset(modOffset),
	.modFullScale(modFullScale), .modLoad(modLoad), .analogSleep(analogSleep),
	.analogReady(analogReady), .outHighZ(outHighZ), .controlWord(controlWord)
);
`default_nettype wire

// [sim/dcc_converter_ctrl_tb_top.sv]
/* bench of the converter control block with a serial host model.
   assumes the host model and the bound checker are compiled first. */
`timescale 1ns/10ps
`default_nettype none
module dcc_converter_ctrl_tb_top;
	localparam int TO = 2000;
	logic        clk_sys, rst, sclkPin, csPin_n, sdioIn, sdioOut, sdioOe, calDone;
	logic        modLoad, analogSleep, analogReady, outHighZ;
	logic [15:0] modCode, controlWord;
	logic [23:0] calOffset, calFullScale, modOffset, modFullScale, rd;
	int          n_fail = 0;
	int          compares = 0;
	dcc_converter_ctrl #(.TIMEOUT_CYC(TO)) DUT (
		.clk_sys(clk_sys), .rst(rst), .sclkPin(sclkPin), .csPin_n(csPin_n), .sdioIn(sdioIn),
		.sdioOut(sdioOut), .sdioOe(sdioOe), .calDone(calDone), .calOffset(calOffset),
		.calFullScale(calFullScale), .modCode(modCode), .modOffset(modOffset),
		.modFullScale(modFullScale), .modLoad(modLoad), .analogSleep(analogSleep),
		.analogReady(analogReady), .outHighZ(outHighZ), .controlWord(controlWord)
	);
	dcc_host_model host (.clk_sys(clk_sys), .sdioOut(sdioOut), .sdioOe(sdioOe), .sclkPin(sclkPin),
		.csPin_n(csPin_n), .sdioWire(sdioIn));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic flag(input string what, input logic exp, input logic got);
		check(what, {23'h000000, exp}, {23'h000000, got});
	endtask
	task automatic rdChk(input string what, input logic [7:0] ins, input int n, input logic [23:0] exp);
		host.xfer(ins, n, 24'h000000, rd);
		check(what, exp, rd);
	endtask
	task automatic t_reset();
		check("control", 24'h002802, {8'h00, controlWord});
		flag("highz", 1'b1, outHighZ);
		flag("sleep", 1'b1, analogSleep);
		rdChk("ofs read", 8'hC8, 3, 24'h000000);
		rdChk("fs read", 8'hCC, 3, 24'h800000);
		$display("reset test done");
	endtask
	task automatic t_regs();
		host.xfer(8'h48, 3, 24'h123456, rd);
		check("ofs", 24'h123456, modOffset);
		rdChk("ofs read", 8'hC8, 3, 24'h123456);
		host.xfer(8'h4C, 3, 24'hA5C3E1, rd);
		check("fs", 24'hA5C3E1, modFullScale);
		host.xfer(8'h0B, 1, 24'h0000FF, rd);
		rdChk("reserved", 8'h8B, 1, 24'h000000);
		rdChk("fs mid", 8'h8D, 1, 24'h0000C3);
		$display("register test done");
	endtask
	task automatic t_order();
		host.xfer(8'h24, 2, 24'h00281A, rd);
		check("ctrl order", 24'h00281A, {8'h00, controlWord});
		rdChk("fs reversed", 8'hCE, 3, 24'h87C3A5);
		host.xfer(8'h05, 1, 24'h000040, rd);
		check("ctrl lsb first", 24'h002802, {8'h00, controlWord});
		$display("order test done");
	endtask
	task automatic t_wake();
		host.xfer(8'h24, 2, 24'h002800, rd);
		flag("sleep", 1'b0, analogSleep);
		flag("ready early", 1'b0, analogReady);
		host.settle(1100);
		flag("ready", 1'b1, analogReady);
		flag("highz", 1'b0, outHighZ);
		$display("wake test done");
	endtask
	task automatic t_data();
		host.xfer(8'h20, 2, 24'h007FFF, rd);
		check("code top", 24'h00FFFF, {8'h00, modCode});
		host.xfer(8'h20, 2, 24'h008000, rd);
		check("code zero", 24'h000000, {8'h00, modCode});
		rdChk("data read", 8'hA0, 2, 24'h008000);
		host.xfer(8'h24, 2, 24'h002840, rd);
		host.xfer(8'h20, 2, 24'h00FFFF, rd);
		check("code binary", 24'h00FFFF, {8'h00, modCode});
		host.xfer(8'h01, 1, 24'h000012, rd);
		check("code one byte", 24'h00FF12, {8'h00, modCode});
		host.xfer(8'h24, 2, 24'h002802, rd);
		flag("asleep", 1'b1, analogSleep);
		flag("asleep highz", 1'b1, outHighZ);
		$display("data test done");
	endtask
	task automatic t_stall();
		host.xfer(8'h48, 1, 24'h000012, rd);
		host.settle(TO + 100);
		check("ofs kept", 24'h123456, modOffset);
		rdChk("after stall", 8'hC8, 3, 24'h123456);
		host.xfer(8'h48, 0, 24'h000000, rd);
		host.linkReset();
		rdChk("after pattern", 8'hC8, 3, 24'h123456);
		$display("stall test done");
	endtask
	task automatic t_cal();
		host.xfer(8'h24, 2, 24'h002801, rd);
		@(negedge clk_sys);
		calOffset = 24'h000123;
		calFullScale = 24'hC00000;
		calDone = 1'b1;
		@(negedge clk_sys);
		calDone = 1'b0;
		host.settle(1100);
		check("cal ofs", 24'h800123, modOffset);
		check("cal fs", 24'hC00000, modFullScale);
		check("mode", 24'h000000, {22'h000000, controlWord[1:0]});
		flag("cal ready", 1'b1, analogReady);
		$display("calibration test done");
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		rst = 1'b1;
		calDone = 1'b0;
		calOffset = 24'h000000;
		calFullScale = 24'h000000;
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		host.settle(20);
		t_reset();
		t_regs();
		t_order();
		t_wake();
		t_data();
		t_stall();
		t_cal();
		results();
	end
	// about four times the expected run
	initial begin
		repeat (60000) @(posedge clk_sys);
		n_fail++;
		$display("watchdog expired");
		results();
	end
endmodule
`default_nettype wire
